//--- rtl/smbc_pkg.sv
// shared constants and carrier types for the bus configuration and timing block
package smbc_pkg;
   // clock source select codes
   localparam logic [1:0] SMBC_CS_TMR0 = 2'h0;
   localparam logic [1:0] SMBC_CS_TMR1 = 2'h1;
   localparam logic [1:0] SMBC_CS_TMR2H = 2'h2;
   localparam logic [1:0] SMBC_CS_TMR2L = 2'h3;
   // overflows per master scl phase
   localparam logic [1:0] SMBC_LOW_OVF = 2'h1;
   localparam logic [1:0] SMBC_HIGH_OVF = 2'h2;
   // sda hold and setup in core clocks
   localparam logic [3:0] SMBC_HOLD_STD = 4'h3;
   localparam logic [3:0] SMBC_HOLD_EXT = 4'hC;
   localparam logic [3:0] SMBC_SETUP_STD = 4'h1;
   localparam logic [3:0] SMBC_SETUP_EXT = 4'hB;
   // source periods of idle bus before it counts as free
   localparam logic [3:0] SMBC_FREE_PERIODS = 4'hA;
   // extra start hold clocks per control code
   localparam logic [3:0] SMBC_START_BASE = 4'h1;
   localparam logic [3:0] SMBC_START_X1 = 4'h2;
   localparam logic [3:0] SMBC_START_X2 = 4'h4;
   localparam logic [3:0] SMBC_START_X3 = 4'h8;
   localparam logic [3:0] SMBC_CNT_MAX = 4'hF;

   // configuration bits from software
   typedef struct packed {
      logic bus_enable_bit;
      logic slave_inhibit;
      logic clock_source_select_hi;
      logic clock_source_select_lo;
      logic sda_timing_extend;
      logic scl_low_timeout_enable;
      logic free_timeout_enable;
      logic [1:0] start_detect_hold_control;
   } smbc_cfg_s;

   // timer overflow pulses on the core clock
   typedef struct packed {
      logic tmr0;
      logic tmr1_or_5;
      logic tmr2_hi;
      logic tmr2_lo;
   } smbc_ovf_s;

   typedef enum logic [5:0] {
      SMBC_M_IDLE = 6'h01,
      SMBC_M_START = 6'h02,
      SMBC_M_LOW = 6'h04,
      SMBC_M_HIGH = 6'h08,
      SMBC_M_STOP = 6'h10,
      SMBC_M_STOPH = 6'h20
   } smbc_mst_e;
endpackage

//--- rtl/smbc_top.sv
// bus configuration, master clocking, start detection and timeouts
`timescale 1ns/1ns
module smbc_top
   import smbc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire smbc_cfg_s cfg,
   input wire smbc_ovf_s ovf,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic mst_run,
   input wire logic mst_sda,
   input wire logic slv_ack,
   input wire logic slv_irq_req,
   output logic slv_irq,
   output logic mst_bit_done,
   output logic start_seen,
   output logic stop_seen,
   output logic transfer_in_progress_flag,
   output logic helper_reload,
   output logic helper_count
);
   // pin synchronisers
   logic scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
      end
   end

   logic en, scl_fall, sda_fall, sda_rise, stop_ev, start_ev, src_ovf, tick;
   logic [3:0] need, hold_n, setup_n;
   smbc_mst_e mst_q;
   assign en = cfg.bus_enable_bit;
   assign scl_fall = scl_p_q && !scl_s2_q;
   assign sda_fall = sda_p_q && !sda_s2_q;
   assign sda_rise = !sda_p_q && sda_s2_q;
   assign stop_ev = en && sda_rise && scl_s2_q;

   // clock source selection and gating
   always_comb
   begin
      src_ovf = ovf.tmr0;
      if ({cfg.clock_source_select_hi, cfg.clock_source_select_lo} == SMBC_CS_TMR1)
         src_ovf = ovf.tmr1_or_5;
      else if ({cfg.clock_source_select_hi, cfg.clock_source_select_lo} == SMBC_CS_TMR2H)
         src_ovf = ovf.tmr2_hi;
      else if ({cfg.clock_source_select_hi, cfg.clock_source_select_lo} == SMBC_CS_TMR2L)
         src_ovf = ovf.tmr2_lo;
   end
   assign tick = en && src_ovf && (mst_q != SMBC_M_IDLE || cfg.free_timeout_enable);

   // required start hold per control code
   always_comb
   begin
      need = SMBC_START_BASE;
      if (cfg.start_detect_hold_control == 2'h1)
         need = SMBC_START_BASE + SMBC_START_X1;
      else if (cfg.start_detect_hold_control == 2'h2)
         need = SMBC_START_BASE + SMBC_START_X2;
      else if (cfg.start_detect_hold_control == 2'h3)
         need = SMBC_START_BASE + SMBC_START_X3;
   end
   assign hold_n = cfg.sda_timing_extend ? SMBC_HOLD_EXT : SMBC_HOLD_STD;
   assign setup_n = cfg.sda_timing_extend ? SMBC_SETUP_EXT : SMBC_SETUP_STD;

   // start detection: time from sda fall (scl high) to scl fall
   logic armed_q;
   logic [3:0] sfc_q;
   assign start_ev = en && armed_q && scl_fall && !sda_s2_q && sfc_q >= need;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         armed_q <= 1'b0;
         sfc_q <= 4'h0;
      end
      else if (!en || sda_rise || scl_fall)
      begin
         armed_q <= 1'b0;
         sfc_q <= 4'h0;
      end
      else if (sda_fall && scl_s2_q)
      begin
         armed_q <= 1'b1;
         sfc_q <= 4'h1;
      end
      else if (armed_q && sfc_q != SMBC_CNT_MAX)
         sfc_q <= sfc_q + 4'h1;
   end

   // free timeout: count source periods with both lines high
   logic [3:0] free_q;
   logic free_ev;
   assign free_ev = cfg.free_timeout_enable && tick && scl_s2_q && sda_s2_q
      && free_q == SMBC_FREE_PERIODS;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         free_q <= 4'h0;
      else if (!en || !cfg.free_timeout_enable || !scl_s2_q || !sda_s2_q)
         free_q <= 4'h0;
      else if (tick && free_q != SMBC_CNT_MAX)
         free_q <= free_q + 4'h1;
   end

   // busy flag, slave inhibit latched at start, event pulses
   logic busy_q, inh_q;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy_q <= 1'b0;
         inh_q <= 1'b0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
         slv_irq <= 1'b0;
      end
      else
      begin
         if (!en)
            busy_q <= 1'b0;
         else if (start_ev)
            busy_q <= 1'b1;
         else if (stop_ev || free_ev)
            busy_q <= 1'b0;
         if (start_ev)
            inh_q <= cfg.slave_inhibit;
         start_seen <= start_ev;
         stop_seen <= stop_ev;
         slv_irq <= en && slv_irq_req && !inh_q;
      end
   end
   assign transfer_in_progress_flag = busy_q;

   // helper timer control for scl low timeout
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         helper_reload <= 1'b0;
         helper_count <= 1'b0;
      end
      else
      begin
         helper_reload <= en && cfg.scl_low_timeout_enable && scl_s2_q;
         helper_count <= en && cfg.scl_low_timeout_enable && !scl_s2_q;
      end
   end

   // master scl generator: low one overflow, high two overflows
   logic [1:0] ovc_q;
   logic [4:0] cyc_q;
   logic [4:0] low_need;
   logic mdrv_q;
   // hold plus setup reaches 23 with extension, so one bit wider than the constants
   assign low_need = 5'(hold_n) + 5'(setup_n);
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mst_q <= SMBC_M_IDLE;
         ovc_q <= 2'h0;
         cyc_q <= 5'h00;
         mdrv_q <= 1'b0;
         mst_bit_done <= 1'b0;
      end
      else
      begin
         mst_bit_done <= 1'b0;
         if (tick)
            ovc_q <= ovc_q + 2'h1;
         if (cyc_q != {1'b1, SMBC_CNT_MAX})
            cyc_q <= cyc_q + 5'h01;
         if (!en)
         begin
            mst_q <= SMBC_M_IDLE;
            mdrv_q <= 1'b0;
         end
         else
         begin
            case (mst_q)
               SMBC_M_IDLE:
               begin
                  ovc_q <= 2'h0;
                  if (mst_run && !busy_q)
                  begin
                     mst_q <= SMBC_M_START;
                     mdrv_q <= 1'b1;
                  end
               end
               SMBC_M_START:
                  if (ovc_q >= SMBC_LOW_OVF)
                  begin
                     mst_q <= SMBC_M_LOW;
                     ovc_q <= 2'h0;
                     cyc_q <= 5'h00;
                  end
               SMBC_M_LOW:
               begin
                  if (cyc_q == 5'(hold_n))
                     mdrv_q <= !mst_sda;
                  if (ovc_q >= SMBC_LOW_OVF && cyc_q >= low_need)
                  begin
                     mst_q <= SMBC_M_HIGH;
                     ovc_q <= 2'h0;
                  end
               end
               SMBC_M_HIGH:
               begin
                  if (!scl_s2_q)
                     ovc_q <= 2'h0; // stretched: high phase starts when scl seen high
                  else if (ovc_q >= SMBC_HIGH_OVF)
                  begin
                     mst_bit_done <= 1'b1;
                     ovc_q <= 2'h0;
                     cyc_q <= 5'h00;
                     mst_q <= mst_run ? SMBC_M_LOW : SMBC_M_STOP;
                  end
               end
               SMBC_M_STOP:
               begin
                  if (cyc_q == 5'(hold_n))
                     mdrv_q <= 1'b1;
                  if (ovc_q >= SMBC_LOW_OVF && cyc_q >= low_need)
                  begin
                     mst_q <= SMBC_M_STOPH;
                     ovc_q <= 2'h0;
                  end
               end
               SMBC_M_STOPH:
                  if (scl_s2_q && ovc_q >= SMBC_LOW_OVF)
                  begin
                     mdrv_q <= 1'b0;
                     mst_q <= SMBC_M_IDLE;
                  end
               default:
                  mst_q <= SMBC_M_IDLE;
            endcase
         end
      end
   end

   // open-drain pin drive, low enable while pulling low
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe_n <= !(en && (mst_q == SMBC_M_LOW || mst_q == SMBC_M_STOP));
         sda_oe_n <= !(en && (mdrv_q || (slv_ack && !inh_q)));
      end
   end

   // scl low phase length in clocks for checking
   logic [15:0] lowlen_q;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         lowlen_q <= 16'h0;
      else if (mst_q == SMBC_M_LOW)
         lowlen_q <= lowlen_q + 16'h1;
      else
         lowlen_q <= 16'h0;
   end

   busy_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      start_ev |=> busy_q) else $error("busy not set on start");
   busy_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (stop_ev || free_ev) && !start_ev |=> !busy_q) else $error("busy not cleared");
   off_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !en |=> scl_oe_n && sda_oe_n && !slv_irq) else $error("lines held when off");
   inh_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      inh_q |=> !slv_irq) else $error("slave irq while inhibited");
   inh_latch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !start_ev && $stable(cfg.slave_inhibit) |=> inh_q == $past(inh_q))
      else $error("inhibit changed outside start");
   helper_ctl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && cfg.scl_low_timeout_enable |=> helper_reload == $past(scl_s2_q)
      && helper_count == !$past(scl_s2_q)) else $error("helper timer control wrong");
   start_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      start_ev |-> sfc_q >= need && sfc_q >= SMBC_START_BASE)
      else $error("start accepted too early");
   low_min_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      mst_q == SMBC_M_LOW ##1 mst_q == SMBC_M_HIGH |-> $past(lowlen_q) >= 16'(low_need))
      else $error("scl low phase too short");
   free_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      free_ev && !start_ev |=> !busy_q ##0 free_q == 4'h0 || !sda_s2_q || scl_s2_q)
      else $error("free timeout lost");
   src_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      tick |-> mst_q != SMBC_M_IDLE || cfg.free_timeout_enable)
      else $error("clock source used when idle");
endmodule

//--- verification/smbc_bus_model.sv
// open-drain bus model of the far-side master with pull-ups on both lines
`timescale 1ns/1ns
module smbc_bus_model (
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   output logic scl,
   output logic sda
);
   logic scl_pull_q = 1'b1;
   logic sda_pull_q = 1'b1;

   // wired-and with pull-ups: a released line reads high
   always_comb scl = scl_pull_q & (scl_oe_n | scl_out);
   always_comb sda = sda_pull_q & (sda_oe_n | sda_out);

   // start: sda falls with scl high, scl follows after gap ns
   task automatic start(input int gap);
      #437 sda_pull_q = 1'b0;
      #(gap) scl_pull_q = 1'b0;
   endtask

   // stop: scl rises with sda low, then sda rises while scl is high
   task automatic stop();
      #400 sda_pull_q = 1'b0;
      #400 scl_pull_q = 1'b1;
      #400 sda_pull_q = 1'b1;
   endtask

   // leave both lines high without a stop (sda rises while scl is low)
   task automatic go_idle();
      #400 sda_pull_q = 1'b1;
      #400 scl_pull_q = 1'b1;
   endtask
endmodule

//--- verification/smbc_top_tb.sv
// self-checking bench for the bus configuration and timing block
`timescale 1ns/1ns
module smbc_top_tb;
   import smbc_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   smbc_cfg_s cfg = '0;
   smbc_ovf_s ovf = '0;
   logic mst_run = 1'b0;
   logic mst_sda = 1'b1;
   logic slv_ack = 1'b0;
   logic slv_irq_req = 1'b0;
   logic scl, sda, scl_out, scl_oe_n, sda_out, sda_oe_n, slv_irq, mst_bit_done;
   logic start_seen, stop_seen, busy, helper_reload, helper_count;
   logic [1:0] tsel = 2'h0;
   int mismatches = 0;
   int checked = 0;
   int tp = 20;
   int tcnt = 0;
   int cyc_n = 0;
   int n_start = 0;
   int n_stop = 0;
   int n_irq = 0;
   int n_done = 0;
   int lo_run = 0;
   int lo_min = 9999;
   int last_done = 0;
   int gap_min = 9999;
   int gap_max = 0;
   int sclo_n = 0;
   int sda_age = 0;
   int hold_min = 9999;
   int setup_min = 9999;
   logic sda_prev = 1'b1;
   logic scl_prev = 1'b1;

   always #50 sys_clk = ~sys_clk;

   smbc_bus_model bus (.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

   smbc_top DUT (.sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .ovf(ovf), .scl_in(scl),
      .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .mst_run(mst_run), .mst_sda(mst_sda), .slv_ack(slv_ack),
      .slv_irq_req(slv_irq_req), .slv_irq(slv_irq), .mst_bit_done(mst_bit_done),
      .start_seen(start_seen), .stop_seen(stop_seen), .transfer_in_progress_flag(busy),
      .helper_reload(helper_reload), .helper_count(helper_count));

   // overflow pulse every tp cycles on the selected timer input, never stopped
   always @(posedge sys_clk)
   begin
      #1;
      tcnt = (tcnt + 1) % tp;
      ovf = '0;
      if (tcnt == 0)
         ovf[3 - tsel] = 1'b1;
   end

   // pulse counters and master phase timing, sampled mid-cycle
   always @(negedge sys_clk)
   begin
      cyc_n++;
      n_start += (start_seen === 1'b1);
      n_stop += (stop_seen === 1'b1);
      n_irq += (slv_irq === 1'b1);
      if (scl_oe_n === 1'b0)
         lo_run++;
      else
      begin
         if (lo_run > 0 && n_done < 3 && lo_run < lo_min)
            lo_min = lo_run;
         lo_run = 0;
      end
      if (mst_bit_done === 1'b1)
      begin
         if (n_done > 0 && cyc_n - last_done < gap_min)
            gap_min = cyc_n - last_done;
         if (n_done > 0 && cyc_n - last_done > gap_max)
            gap_max = cyc_n - last_done;
         last_done = cyc_n;
         n_done++;
      end
      // sda hold after scl pulled low, sda setup before scl released
      if (sda_oe_n !== sda_prev)
      begin
         if (scl_oe_n === 1'b0 && sclo_n < hold_min)
            hold_min = sclo_n;
         sda_age = 0;
      end
      else
         sda_age++;
      if (scl_oe_n === 1'b1 && scl_prev === 1'b0 && sda_age < setup_min)
         setup_min = sda_age;
      sclo_n = (scl_oe_n === 1'b0) ? sclo_n + 1 : 0;
      sda_prev = sda_oe_n;
      scl_prev = scl_oe_n;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic timeout();
      mismatches++;
      finish_test();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic s_start_stop();
      n_start = 0;
      n_stop = 0;
      bus.start(400);
      cyc(6);
      chk({n_start[1:0], busy}, 3'h3);
      bus.stop();
      cyc(6);
      chk({n_stop[1:0], busy}, 3'h2);
   endtask

   // long enough sda-to-scl gaps for every hold code, too short ones for codes 1 to 3
   task automatic s_start_hold();
      int ex;
      for (int c = 0; c < 4; c++)
      begin
         ex = (c == 0) ? 0 : (1 << c);
         cfg.start_detect_hold_control = c[1:0];
         for (int lng = (c == 0); lng < 2; lng++)
         begin
            n_start = 0;
            bus.start(lng ? ex * 100 + 130 : ex * 100 - 130);
            cyc(6);
            chk(n_start, lng);
            bus.stop();
            cyc(6);
         end
      end
      cfg.start_detect_hold_control = 2'h0;
   endtask

   task automatic s_helper();
      cfg.scl_low_timeout_enable = 1'b1;
      bus.start(400);
      cyc(6);
      chk({helper_reload, helper_count}, 2'h1);
      bus.stop();
      cyc(6);
      chk({helper_reload, helper_count}, 2'h2);
      cfg.scl_low_timeout_enable = 1'b0;
      cyc(3);
      chk({helper_reload, helper_count}, 2'h0);
   endtask

   task automatic pulse_irq();
      slv_irq_req = 1'b1;
      cyc(1);
      slv_irq_req = 1'b0;
      cyc(4);
   endtask

   task automatic s_inhibit();
      bus.start(400);
      cyc(4);
      n_irq = 0;
      pulse_irq();
      chk(n_irq, 1);
      cfg.slave_inhibit = 1'b1;
      pulse_irq();
      chk(n_irq, 2);
      bus.stop();
      cyc(4);
      bus.start(400);
      cyc(4);
      slv_ack = 1'b1;
      pulse_irq();
      chk({n_irq[1:0], sda_oe_n}, 3'h5);
      slv_ack = 1'b0;
      bus.stop();
      cyc(4);
      cfg.slave_inhibit = 1'b0;
   endtask

   // idle bus after a start: wrong source, then right one; last pass without enable
   task automatic s_free();
      for (int c = 0; c < 5; c++)
      begin
         cfg.free_timeout_enable = (c < 4);
         {cfg.clock_source_select_hi, cfg.clock_source_select_lo} = c[1:0];
         tsel = c[1:0] ^ 2'h1;
         bus.start(400);
         bus.go_idle();
         cyc(12 * tp);
         chk(busy, 1'b1);
         tsel = c[1:0];
         cyc(9 * tp);
         chk(busy, 1'b1);
         cyc(4 * tp);
         chk(busy, c == 4);
         if (c == 4)
            bus.stop();
         cyc(6);
      end
      tsel = 2'h0;
   endtask

   task automatic s_disable();
      cfg.bus_enable_bit = 1'b0;
      slv_ack = 1'b1;
      slv_irq_req = 1'b1;
      mst_run = 1'b1;
      n_irq = 0;
      cyc(2);
      repeat (40)
      begin
         chk({scl_oe_n, sda_oe_n}, 2'h3);
         cyc(1);
      end
      chk(n_irq, 0);
      mst_run = 1'b0;
      slv_ack = 1'b0;
      slv_irq_req = 1'b0;
      cyc(2);
      cfg.bus_enable_bit = 1'b1;
      cyc(3);
   endtask

   task automatic s_master(input logic ext);
      cfg.sda_timing_extend = ext;
      n_done = 0;
      lo_min = 9999;
      gap_min = 9999;
      gap_max = 0;
      hold_min = 9999;
      setup_min = 9999;
      mst_run = 1'b1;
      for (int i = 0; i < 4000 && n_done < 4; i++)
         cyc(1);
      mst_run = 1'b0;
      if (n_done < 4)
         timeout();
      chk(lo_min >= tp, 1'b1);
      chk(gap_min >= 2 * tp && gap_max <= 4 * tp + 30, 1'b1);
      chk({scl_out, sda_out}, 2'h0);
      chk(hold_min >= (ext ? SMBC_HOLD_EXT : SMBC_HOLD_STD), 1'b1);
      chk(setup_min >= (ext ? SMBC_SETUP_EXT : lo_min - 4), 1'b1);
      for (int i = 0; i < 2000 && busy !== 1'b0; i++)
         cyc(1);
      chk(busy, 1'b0);
      cfg.sda_timing_extend = 1'b0;
      cyc(3);
   endtask

   initial
   begin
      repeat (12) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      chk({scl_oe_n, sda_oe_n, busy}, 3'h6);
      cyc(3);
      cfg.bus_enable_bit = 1'b1;
      s_start_stop();
      s_start_hold();
      s_helper();
      s_inhibit();
      s_free();
      s_disable();
      s_master(1'b0);
      s_master(1'b1);
      finish_test();
   end
endmodule
